// file: watchdog_downcounter.v
// software-fault watchdog with free-running 7-bit downcounter and AXI4-Lite access
`timescale 1ns/100ps
`include "watchdog_downcounter_map.vh"

// Function
// - countdown steps down once every 16000 machine cycles of the prescaler
// - timeout programmable in 64 steps of one countdown period each
// - when active, countdown passing 40h to 3Fh starts a reset pulse
// - countdown runs whether active or not, stopped during a reset sequence; only the reset depends on activation
// - inactive after reset; once active, cannot be deactivated until reset
// - write with activation set and top timer bit clear resets at once
// - active and no halt option: HALT causes reset instead of halting
// - with halt option selected, HALT enters halt without watchdog reset
// - hardware watchdog option makes it always active, activation bit unused
// - activation bit 7 set by software, cleared only by reset
// - bits 6 to 0 read back the current countdown value
// - control register resets to 7Fh
// - at 8 MHz timeout spans 0-2 ms (C0h) to 126-128 ms (FFh)
// - reset phase of 256 or 4096 cycles follows the watchdog reset
module watchdog_downcounter #(
    parameter ADDR_W = 8,
    parameter [15:0] PRESCALE_CYCLES = `WDG_PRESCALE_CYCLES,
    parameter [15:0] RST_PULSE_CYCLES = `WDG_RST_PULSE_CYC
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_rst_b,
    // axi4-lite write address
    input wire i_s_axi_awvalid,
    input wire [ADDR_W-1:0] i_s_axi_awaddr,
    input wire [2:0] i_s_axi_awprot,
    output reg o_s_axi_awready,
    // axi4-lite write data
    input wire i_s_axi_wvalid,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    output reg o_s_axi_wready,
    // axi4-lite write response
    output reg o_s_axi_bvalid,
    output reg [1:0] o_s_axi_bresp,
    input wire i_s_axi_bready,
    // axi4-lite read address
    input wire i_s_axi_arvalid,
    input wire [ADDR_W-1:0] i_s_axi_araddr,
    input wire [2:0] i_s_axi_arprot,
    output reg o_s_axi_arready,
    // axi4-lite read data
    output reg o_s_axi_rvalid,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    input wire i_s_axi_rready,
    // option settings
    input wire i_hw_watchdog_option,
    input wire i_halt_without_reset_option,
    input wire i_long_reset_phase,
    // cpu halt handshake
    input wire i_halt_req,
    output reg o_halt_enter,
    // reset generation and status
    output reg o_sys_rst_b,
    output reg o_reset_phase,
    output reg o_watchdog_active
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_PULSE = 2'h1;
    localparam [1:0] ST_PHASE = 2'h2;

    localparam [ADDR_W-1:0] CTRL_ADDR = `WDG_CTRL_ADDR;
    localparam [15:0] PHASE_SHORT = `WDG_PHASE_SHORT;
    localparam [15:0] PHASE_LONG = `WDG_PHASE_LONG;

    // word-aligned match against the control register
    function hit_ctrl;
        input [ADDR_W-1:0] addr;
        begin
            hit_ctrl = (addr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]);
        end
    endfunction

    // next value of a 16-bit cycle counter
    function [15:0] inc16;
        input [15:0] val;
        begin
            inc16 = val + 16'h0001;
        end
    endfunction

    // write channel holding state
    reg aw_got_q;
    reg w_got_q;
    reg [ADDR_W-1:0] aw_addr_q;
    reg [7:0] w_data_q;
    reg w_strb_q;

    // watchdog core state
    reg act_q;
    reg act_d;
    reg [6:0] cnt_q;
    reg [6:0] cnt_d;
    reg [15:0] psc_q;
    reg [15:0] psc_d;
    reg [1:0] state_q;
    reg [15:0] seq_q;
    reg trig;
    reg halt_ok;

    wire aw_fire;
    wire w_fire;
    wire ar_fire;
    wire wr_go;
    wire wr_ctrl;
    wire act_eff;
    wire tick;
    wire [15:0] phase_len;
    wire seq_done;
    wire roll_hit;
    wire [15:0] seq_last;

    assign aw_fire = i_s_axi_awvalid & o_s_axi_awready;
    assign w_fire = i_s_axi_wvalid & o_s_axi_wready;
    assign ar_fire = i_s_axi_arvalid & o_s_axi_arready;
    // a new write waits until the previous response has been taken
    assign wr_go = aw_got_q & w_got_q & ~o_s_axi_bvalid;
    assign wr_ctrl = wr_go & hit_ctrl(aw_addr_q) & w_strb_q;
    assign act_eff = act_q | i_hw_watchdog_option;
    assign tick = (psc_q == PRESCALE_CYCLES - 16'h0001);
    assign phase_len = i_long_reset_phase ? PHASE_LONG : PHASE_SHORT;

    // reset sequence timing
    assign roll_hit = (cnt_q == `WDG_ROLL_VAL);
    // pulse and phase share one counter; each ends on its own last value
    assign seq_last = (state_q == ST_PULSE) ? (RST_PULSE_CYCLES - 16'h0001)
        : (phase_len - 16'h0001);
    assign seq_done = (seq_q == seq_last);

    // write address and data taken independently, in either order
    // each ready is a one-cycle pulse, so a held request is taken once
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
        end else begin
            o_s_axi_awready <= i_s_axi_awvalid & ~o_s_axi_awready & ~aw_got_q;
            o_s_axi_wready <= i_s_axi_wvalid & ~o_s_axi_wready & ~w_got_q;
            if (aw_fire) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= i_s_axi_awaddr;
            end else if (wr_go) begin
                aw_got_q <= 1'b0;
            end
            if (w_fire) begin
                w_got_q <= 1'b1;
                w_data_q <= i_s_axi_wdata[7:0];
                w_strb_q <= i_s_axi_wstrb[0];
            end else if (wr_go) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // write response after both halves are in
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `AXI_RESP_OKAY;
        end else begin
            if (wr_go) begin
                o_s_axi_bvalid <= 1'b1;
                if (hit_ctrl(aw_addr_q)) begin
                    o_s_axi_bresp <= `AXI_RESP_OKAY;
                end else begin
                    o_s_axi_bresp <= `AXI_RESP_SLVERR;
                end
            end else if (o_s_axi_bvalid & i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    // no new read address while read data still waits for rready
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `AXI_RESP_OKAY;
        end else begin
            o_s_axi_arready <= i_s_axi_arvalid & ~o_s_axi_arready & ~o_s_axi_rvalid;
            if (ar_fire) begin
                o_s_axi_rvalid <= 1'b1;
                if (hit_ctrl(i_s_axi_araddr)) begin
                    o_s_axi_rdata <= {24'h000000, act_q, cnt_q};
                    o_s_axi_rresp <= `AXI_RESP_OKAY;
                end else begin
                    o_s_axi_rdata <= 32'h00000000;
                    o_s_axi_rresp <= `AXI_RESP_SLVERR;
                end
            end else if (o_s_axi_rvalid & i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    // prescaler runs regardless of writes; held at zero during a reset sequence
    always @* begin
        psc_d = psc_q;
        if (state_q != ST_IDLE) begin
            psc_d = 16'h0000;
        end else if (tick) begin
            psc_d = 16'h0000;
        end else begin
            psc_d = inc16(psc_q);
        end
    end

    // countdown and activation; a write wins over a same-cycle tick
    always @* begin
        act_d = act_q;
        cnt_d = cnt_q;
        if ((state_q == ST_PULSE) && seq_done) begin
            // watchdog comes back inactive at its reset value
            act_d = `WDG_ACT_RESET;
            cnt_d = `WDG_CNT_RESET;
        end else if (state_q == ST_IDLE) begin
            if (wr_ctrl) begin
                act_d = act_q | w_data_q[`WDG_ACT_BIT];
                cnt_d = w_data_q[`WDG_CNT_MSB:0];
            end else if (tick) begin
                cnt_d = cnt_q - 7'h01;
            end
        end
    end

    // reset triggers and halt grant, looked at only while idle
    always @* begin
        trig = 1'b0;
        halt_ok = 1'b0;
        if (state_q == ST_IDLE) begin
            if (wr_ctrl) begin
                if ((act_d | i_hw_watchdog_option) & ~w_data_q[`WDG_TOP_BIT]) begin
                    trig = 1'b1;
                end
            end else if (tick && act_eff && roll_hit) begin
                trig = 1'b1;
            end
            if (i_halt_req) begin
                if (act_eff && !i_halt_without_reset_option) begin
                    trig = 1'b1;
                end else begin
                    halt_ok = 1'b1;
                end
            end
        end
    end

    // prescaler, countdown and activation registers
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            psc_q <= 16'h0000;
            act_q <= `WDG_ACT_RESET;
            cnt_q <= `WDG_CNT_RESET;
        end else begin
            psc_q <= psc_d;
            act_q <= act_d;
            cnt_q <= cnt_d;
        end
    end

    // reset sequence: low pulse first, then the reset phase
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            seq_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    seq_q <= 16'h0000;
                    if (trig) begin
                        state_q <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (seq_done) begin
                        state_q <= ST_PHASE;
                        seq_q <= 16'h0000;
                    end else begin
                        seq_q <= inc16(seq_q);
                    end
                end
                ST_PHASE: begin
                    if (seq_done) begin
                        state_q <= ST_IDLE;
                        seq_q <= 16'h0000;
                    end else begin
                        seq_q <= inc16(seq_q);
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    seq_q <= 16'h0000;
                end
            endcase
        end
    end

    // registered outputs; reset and reset phase follow the sequence state, halt and active do not
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sys_rst_b <= 1'b1;
            o_reset_phase <= 1'b0;
            o_halt_enter <= 1'b0;
            o_watchdog_active <= 1'b0;
        end else begin
            o_halt_enter <= halt_ok & ~trig;
            o_watchdog_active <= act_d | i_hw_watchdog_option;
            case (state_q)
                ST_IDLE: begin
                    o_sys_rst_b <= ~trig;
                    o_reset_phase <= 1'b0;
                end
                ST_PULSE: begin
                    o_sys_rst_b <= seq_done;
                    o_reset_phase <= seq_done;
                end
                ST_PHASE: begin
                    o_sys_rst_b <= 1'b1;
                    o_reset_phase <= ~seq_done;
                end
                default: begin
                    o_sys_rst_b <= 1'b1;
                    o_reset_phase <= 1'b0;
                end
            endcase
        end
    end

endmodule // watchdog_downcounter

// file: watchdog_downcounter_map.vh
// register map, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_DOWNCOUNTER_MAP_VH
`define WATCHDOG_DOWNCOUNTER_MAP_VH

// register index as printed; byte address is four times the index
`define WDG_CTRL_IDX 6'h2E
`define WDG_CTRL_ADDR {`WDG_CTRL_IDX, 2'h0}

// control register fields
`define WDG_ACT_BIT 7
`define WDG_TOP_BIT 6
`define WDG_CNT_MSB 6
`define WDG_CTRL_RESET 8'h7F
`define WDG_ACT_RESET 1'b0
`define WDG_CNT_RESET 7'h7F
`define WDG_ROLL_VAL 7'h40

// countdown pacing
`define WDG_PRESCALE_CYCLES 16'h3E80
`define WDG_STEPS 64

// reset pulse: 30000 ns typical at a 250 MHz clock gives 7500 cycles
`define WDG_RST_PULSE_NS 30000
`define WDG_CLK_MHZ 250
`define WDG_RST_PULSE_CYC 16'h1D4C

// reset phase lengths in clock cycles
`define WDG_PHASE_SHORT 16'h0100
`define WDG_PHASE_LONG 16'h1000

// axi response codes
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// file: watchdog_downcounter_asserts.sv
// concurrent checks on the watchdog downcounter ports
`timescale 1ns/100ps
`include "watchdog_downcounter_map.vh"
module watchdog_downcounter_asserts #(
    parameter [15:0] RST_PULSE_CYCLES = 16'h0004
) (
    input wire i_sys_clk,
    input wire i_rst_b,
    input wire i_s_axi_arvalid,
    input wire [7:0] i_s_axi_araddr,
    input wire o_s_axi_arready,
    input wire o_s_axi_rvalid,
    input wire [31:0] o_s_axi_rdata,
    input wire [1:0] o_s_axi_rresp,
    input wire i_halt_req,
    input wire i_halt_without_reset_option,
    input wire i_hw_watchdog_option,
    input wire o_halt_enter,
    input wire o_sys_rst_b,
    input wire o_reset_phase,
    input wire o_watchdog_active
);
    reg [15:0] low_q;
    wire idle = o_sys_rst_b && !o_reset_phase;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // length of the current low stretch of the reset output
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) low_q <= 16'h0000;
        else low_q <= o_sys_rst_b ? 16'h0000 : low_q + 16'h0001;
    end
    a_pulse_len: assert property ($rose(o_sys_rst_b) |-> low_q == RST_PULSE_CYCLES)
        else $error("reset pulse length wrong");
    a_phase_follows: assert property ($rose(o_sys_rst_b) |-> ##[0:1] o_reset_phase)
        else $error("reset phase missing after pulse");
    a_halt_grant: assert property (i_halt_req && idle && (!o_watchdog_active
        || i_halt_without_reset_option) |=> o_halt_enter && o_sys_rst_b)
        else $error("halt not granted");
    a_halt_reset: assert property (i_halt_req && idle && o_watchdog_active
        && !i_halt_without_reset_option |=> !o_sys_rst_b && !o_halt_enter)
        else $error("halt did not reset");
    a_active_sticky: assert property (o_watchdog_active && idle && !i_hw_watchdog_option
        && !$past(i_hw_watchdog_option) |=> o_watchdog_active)
        else $error("watchdog deactivated");
    a_unmapped_read: assert property (i_s_axi_arvalid && o_s_axi_arready
        && i_s_axi_araddr[7:2] != `WDG_CTRL_IDX |=> o_s_axi_rvalid
        && o_s_axi_rresp == `AXI_RESP_SLVERR && o_s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_rdata_upper: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_act_cleared: assert property ($fell(o_reset_phase)
        |-> !o_watchdog_active || i_hw_watchdog_option)
        else $error("activation kept over reset");
endmodule // watchdog_downcounter_asserts

// file: watchdog_downcounter_tb.sv
// self-checking bench of the watchdog downcounter
`timescale 1ns/100ps
`include "watchdog_downcounter_map.vh"
module watchdog_downcounter_tb;
    reg clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    reg hw = 0, hopt = 0, lph = 0, hreq = 0;
    reg [7:0] awa = 8'h00, ara = 8'h00;
    reg [31:0] wd = 32'h00000000, seed = 32'h8636C7F6, got;
    reg [1:0] rsp;
    wire awr, wrd, bv, arr, rv, hen, srst_b, rph, act;
    wire [1:0] br, rr;
    wire [31:0] rd;
    integer err_count = 0, checks_done = 0, n, t0, ph, i;
    initial forever #2 clk = ~clk;
    watchdog_downcounter #(.PRESCALE_CYCLES(16'h0008), .RST_PULSE_CYCLES(16'h0004))
    i_watchdog_downcounter (.i_sys_clk(clk), .i_rst_b(rst_b), .i_s_axi_awvalid(awv),
        .i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0), .o_s_axi_awready(awr),
        .i_s_axi_wvalid(wv), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .o_s_axi_wready(wrd),
        .o_s_axi_bvalid(bv), .o_s_axi_bresp(br), .i_s_axi_bready(bry),
        .i_s_axi_arvalid(arv), .i_s_axi_araddr(ara), .i_s_axi_arprot(3'h0),
        .o_s_axi_arready(arr), .o_s_axi_rvalid(rv), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
        .i_s_axi_rready(rry), .i_hw_watchdog_option(hw), .i_halt_without_reset_option(hopt),
        .i_long_reset_phase(lph), .i_halt_req(hreq), .o_halt_enter(hen),
        .o_sys_rst_b(srst_b), .o_reset_phase(rph), .o_watchdog_active(act));
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    function in_rng(input [31:0] v, input [6:0] lo, input [6:0] hi);
        in_rng = v[31:7] === 25'h0000000 && v[6:0] >= lo && v[6:0] <= hi;
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            if (err_count == 0 && checks_done > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task tmo;
        if (n >= 6000) begin
            err_count = err_count + 1;
            results;
        end
    endtask
    task axw(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            awv <= 1; wv <= 1; bry <= 1; awa <= a; wd <= {seed[31:8], d};
            n = 0;
            while ((awv || wv || bv !== 1'b1) && n < 6000) begin
                @(posedge clk);
                n = n + 1;
                if (awr) awv <= 0;
                if (wrd) wv <= 0;
            end
            rsp = br; bry <= 0;
            tmo;
        end
    endtask
    task axr(input [7:0] a);
        begin
            @(posedge clk);
            arv <= 1; rry <= 1; ara <= a;
            n = 0;
            while (rv !== 1'b1 && n < 6000) begin
                @(posedge clk);
                n = n + 1;
                if (arr) arv <= 0;
            end
            got = rd; rsp = rr; rry <= 0;
            tmo;
        end
    endtask
    task rst_seq;
        begin
            n = 0; ph = 0;
            while (srst_b !== 1'b0 && n < 6000) begin @(posedge clk); n = n + 1; end
            t0 = n;
            while (rph !== 1'b1 && n < 6000) begin @(posedge clk); n = n + 1; end
            while (rph === 1'b1 && n < 6000) begin @(posedge clk); n = n + 1; ph = ph + 1; end
            tmo;
        end
    endtask
    task halt;
        begin
            @(posedge clk); hreq <= 1;
            @(posedge clk); hreq <= 0;
            @(posedge clk);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1;
        axr(`WDG_CTRL_ADDR); chk(got, {24'h000000, `WDG_CTRL_RESET});
        chk(act, 1'b0);
        axr(8'h10); chk(rsp, `AXI_RESP_SLVERR);
        axw(8'h14, 8'h80); chk({rsp, srst_b}, {`AXI_RESP_SLVERR, 1'b1});
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            axw(`WDG_CTRL_ADDR, {2'b01, seed[5:0]});
            chk(rsp, `AXI_RESP_OKAY);
            axr(`WDG_CTRL_ADDR);
            chk(in_rng(got, {1'b1, seed[5:0]} - 7'h01, {1'b1, seed[5:0]}), 1'b1);
        end
        // inactive countdown crosses 40h without a reset
        axw(`WDG_CTRL_ADDR, 8'h45);
        repeat (80) @(posedge clk);
        axr(`WDG_CTRL_ADDR); chk(in_rng(got, 7'h38, 7'h3B), 1'b1);
        chk({srst_b, rph}, 2'b10);
        halt;
        chk(hen, 1'b1);
        axw(`WDG_CTRL_ADDR, 8'hC2);
        axw(`WDG_CTRL_ADDR, 8'h42);
        chk(act, 1'b1);
        rst_seq; chk(t0 >= 15 && t0 <= 26, 1'b1);
        for (i = 0; i < 2; i = i + 1) begin
            lph <= i[0];
            axw(`WDG_CTRL_ADDR, 8'h80);
            rst_seq;
            chk(ph, i ? `WDG_PHASE_LONG : `WDG_PHASE_SHORT);
            axr(`WDG_CTRL_ADDR); chk(got, 32'h0000007F);
        end
        axw(`WDG_CTRL_ADDR, 8'hFF);
        hopt <= 1;
        halt; chk({hen, srst_b}, 2'b11);
        hopt <= 0;
        halt; rst_seq; chk(t0 < 3, 1'b1);
        hw <= 1;
        axw(`WDG_CTRL_ADDR, 8'h7F); chk({act, srst_b}, 2'b11);
        axw(`WDG_CTRL_ADDR, 8'h3F); rst_seq; chk(t0 < 4, 1'b1);
        hw <= 0;
        results;
    end
endmodule // watchdog_downcounter_tb
bind watchdog_downcounter watchdog_downcounter_asserts #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES))
    i_watchdog_downcounter_asserts (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_s_axi_arvalid(i_s_axi_arvalid), .i_s_axi_araddr(i_s_axi_araddr),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
    .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
    .i_halt_req(i_halt_req), .i_halt_without_reset_option(i_halt_without_reset_option),
    .i_hw_watchdog_option(i_hw_watchdog_option), .o_halt_enter(o_halt_enter),
    .o_sys_rst_b(o_sys_rst_b), .o_reset_phase(o_reset_phase),
    .o_watchdog_active(o_watchdog_active));
